// File: rtl/adc_input_mux_map.svh
// register addresses, field positions, reset values and codes of the converter input control
`ifndef ADC_INPUT_MUX_MAP_SVH
`define ADC_INPUT_MUX_MAP_SVH

`define INPUT_PAIR_CONFIG_ADDR      8'hBA
`define CHANNEL_SELECT_ADDR         8'hBB
`define CONVERTER_CONFIG_ADDR       8'hBC
`define PORT_PIN_SELECT_ADDR        8'hBD
`define CONVERTER_CONTROL_ADDR      8'hE8

`define PAIR_ZERO_ONE_BIT           0
`define PAIR_TWO_THREE_BIT          1
`define HV_SIGNED_BIT               2
`define PORT_GROUP_DIFF_BIT         3
`define PAIR_CFG_MASK               8'h0F
`define CHANNEL_CODE_MASK           8'h0F
`define ENABLE_BIT                  7
`define BUSY_BIT                    4
`define GAIN_LSB                    0
`define GAIN_MSB                    2
`define EVEN_PIN_MASK               8'h55
`define ODD_PIN_MASK                8'hAA

`define INPUT_PAIR_CONFIG_RESET     8'h00
`define CHANNEL_SELECT_RESET        8'h00
`define PORT_PIN_SELECT_RESET       8'h00
`define GAIN_RESET                  3'h0

`define GAIN_X1                     3'h0
`define GAIN_X2                     3'h1
`define GAIN_X4                     3'h2
`define GAIN_X8                     3'h3
`define GAIN_X16                    3'h4
`define GAIN_HALF                   3'h6

`define CHAN_HV                     4'h4
`define CHAN_GND                    4'h5
`define CHAN_EVEN                   4'h6
`define CHAN_ODD                    4'h7

`endif

// File: rtl/adc_input_mux_pkg.sv
// types shared by the converter input control
package adc_input_mux_pkg;

    // analog sources that the input multiplexer can connect
    typedef enum logic [3:0] {
        SRC_AIN0, SRC_AIN1, SRC_AIN2, SRC_AIN3, SRC_HV_AMP, SRC_GND,
        SRC_EVEN_PORT, SRC_ODD_PORT, SRC_TEMP, SRC_HV_REF
    } src_t;

    // route handed to the analog multiplexer and gain stage
    typedef struct packed {
        src_t       pos_src;
        src_t       neg_src;
        logic       differential;
        logic [2:0] gain;
        logic [7:0] port_pins;
    } route_t;

    typedef enum logic {
        ST_IDLE,
        ST_CONVERT
    } conv_state_t;

endpackage : adc_input_mux_pkg

// File: rtl/adc_input_mux_config.sv
// input multiplexer, gain and result-format control of the 10-bit converter
// How it works
// - enable bit off keeps whole converter shut down
// - nine channels into a 10-bit converter
// - reset leaves every input pair single-ended
// - gain field in configuration register sets gain
// - gains 0.5, 2, 4, 8, 16 supported
// - gain returns to unity at reset
// - any number of port pins enabled together
// - even pins share one input, odd another
// - high-voltage amplifier selectable like any channel
// - pair config bits 7-4 read zero, ignore writes
// - bit 3 pairs even/odd port groups
// - bit 2 makes high-voltage result signed
// - bit 1 pairs inputs two and three
// - bit 0 pairs inputs zero and one
// - differential results two's complement, single-ended unsigned
// - channel code picks input, 1xxx temperature
// - port pin select bits enable pins, reset zero
`timescale 1ns/1ns
`default_nettype none
`include "adc_input_mux_map.svh"

module adc_input_mux_config (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic [7:0]                 sfr_addr,
    input  wire logic                       sfr_wr,
    input  wire logic                       sfr_rd,
    input  wire logic [7:0]                 sfr_wdata,
    output logic      [7:0]                 sfr_rdata,
    input  wire logic                       conv_start,
    input  wire logic                       conv_done,
    input  wire logic [9:0]                 conv_code,
    output logic                            converter_shutdown,
    output logic                            conv_busy,
    output adc_input_mux_pkg::route_t       route,
    output logic [15:0]                     result,
    output logic                            result_valid
);

    logic [3:0]                     pair_cfg_r,   pair_cfg_nxt;
    logic [3:0]                     chan_r,       chan_nxt;
    logic [7:0]                     pins_r,       pins_nxt;
    logic [2:0]                     gain_r,       gain_nxt;
    logic                           enable_r,     enable_nxt;
    logic [7:0]                     rdata_r,      rdata_nxt;
    adc_input_mux_pkg::conv_state_t state_r,      state_nxt;
    adc_input_mux_pkg::route_t      route_r,      route_nxt;
    logic [15:0]                    result_r,     result_nxt;
    logic                           valid_r,      valid_nxt;
    adc_input_mux_pkg::route_t      decoded;

    // channel code plus pairing bits give the positive and negative source
    always_comb begin
        decoded              = '0;
        decoded.pos_src      = adc_input_mux_pkg::SRC_GND;
        decoded.neg_src      = adc_input_mux_pkg::SRC_GND;
        decoded.gain         = gain_r;
        decoded.port_pins    = pins_r;
        if (chan_r[3]) begin
            decoded.pos_src  = adc_input_mux_pkg::SRC_TEMP;
        end else begin
            case (chan_r[2:1])
                2'h0: begin
                    if (pair_cfg_r[`PAIR_ZERO_ONE_BIT]) begin
                        decoded.pos_src      = adc_input_mux_pkg::SRC_AIN0;
                        decoded.neg_src      = adc_input_mux_pkg::SRC_AIN1;
                        decoded.differential = 1'b1;
                    end else begin
                        decoded.pos_src = chan_r[0] ? adc_input_mux_pkg::SRC_AIN1
                                                    : adc_input_mux_pkg::SRC_AIN0;
                    end
                end
                2'h1: begin
                    if (pair_cfg_r[`PAIR_TWO_THREE_BIT]) begin
                        decoded.pos_src      = adc_input_mux_pkg::SRC_AIN2;
                        decoded.neg_src      = adc_input_mux_pkg::SRC_AIN3;
                        decoded.differential = 1'b1;
                    end else begin
                        decoded.pos_src = chan_r[0] ? adc_input_mux_pkg::SRC_AIN3
                                                    : adc_input_mux_pkg::SRC_AIN2;
                    end
                end
                2'h2: begin
                    if (pair_cfg_r[`HV_SIGNED_BIT]) begin
                        decoded.pos_src      = adc_input_mux_pkg::SRC_HV_AMP;
                        decoded.neg_src      = adc_input_mux_pkg::SRC_HV_REF;
                        decoded.differential = 1'b1;
                    end else if (chan_r == `CHAN_HV) begin
                        decoded.pos_src = adc_input_mux_pkg::SRC_HV_AMP;
                    end else begin
                        decoded.pos_src = adc_input_mux_pkg::SRC_GND;
                    end
                end
                default: begin
                    if (pair_cfg_r[`PORT_GROUP_DIFF_BIT]) begin
                        decoded.pos_src      = adc_input_mux_pkg::SRC_EVEN_PORT;
                        decoded.neg_src      = adc_input_mux_pkg::SRC_ODD_PORT;
                        decoded.differential = 1'b1;
                    end else begin
                        decoded.pos_src = chan_r[0] ? adc_input_mux_pkg::SRC_ODD_PORT
                                                    : adc_input_mux_pkg::SRC_EVEN_PORT;
                    end
                end
            endcase
        end
    end

    // register writes and registered read data; reserved bits stay zero
    always_comb begin
        pair_cfg_nxt = pair_cfg_r;
        chan_nxt     = chan_r;
        pins_nxt     = pins_r;
        gain_nxt     = gain_r;
        enable_nxt   = enable_r;
        rdata_nxt    = rdata_r;
        if (sfr_wr) begin
            case (sfr_addr)
                `INPUT_PAIR_CONFIG_ADDR: pair_cfg_nxt = sfr_wdata[3:0];
                `CHANNEL_SELECT_ADDR:    chan_nxt     = sfr_wdata[3:0];
                `PORT_PIN_SELECT_ADDR:   pins_nxt     = sfr_wdata;
                `CONVERTER_CONFIG_ADDR:  gain_nxt     = sfr_wdata[`GAIN_MSB:`GAIN_LSB];
                `CONVERTER_CONTROL_ADDR: enable_nxt   = sfr_wdata[`ENABLE_BIT];
                default: ;
            endcase
        end
        if (sfr_rd) begin
            case (sfr_addr)
                `INPUT_PAIR_CONFIG_ADDR: rdata_nxt = {4'h0, pair_cfg_r};
                `CHANNEL_SELECT_ADDR:    rdata_nxt = {4'h0, chan_r};
                `PORT_PIN_SELECT_ADDR:   rdata_nxt = pins_r;
                `CONVERTER_CONFIG_ADDR:  rdata_nxt = {5'h00, gain_r};
                `CONVERTER_CONTROL_ADDR: rdata_nxt = {enable_r, 2'h0,
                                                      state_r == adc_input_mux_pkg::ST_CONVERT,
                                                      4'h0};
                default:                 rdata_nxt = 8'h00;
            endcase
        end
    end

    // reset gives single-ended pairs, unity gain and no port pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pair_cfg_r <= 4'h0;
            chan_r     <= 4'h0;
            pins_r     <= 8'h00;
            gain_r     <= `GAIN_RESET;
            enable_r   <= 1'b0;
            rdata_r    <= 8'h00;
        end else begin
            pair_cfg_r <= pair_cfg_nxt;
            chan_r     <= chan_nxt;
            pins_r     <= pins_nxt;
            gain_r     <= gain_nxt;
            enable_r   <= enable_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

    // conversion sequence: the route is frozen at start so a write mid-way cannot
    // disturb the sample being taken; disabling aborts and drops the result
    always_comb begin
        state_nxt  = state_r;
        route_nxt  = route_r;
        result_nxt = result_r;
        valid_nxt  = 1'b0;
        case (state_r)
            adc_input_mux_pkg::ST_IDLE: begin
                if (enable_r && conv_start) begin
                    route_nxt = decoded;
                    state_nxt = adc_input_mux_pkg::ST_CONVERT;
                end
            end
            adc_input_mux_pkg::ST_CONVERT: begin
                if (!enable_r) begin
                    state_nxt = adc_input_mux_pkg::ST_IDLE;
                end else if (conv_done) begin
                    // offset-binary core code: flipping the top bit gives two's complement
                    if (route_r.differential) begin
                        result_nxt = {{6{~conv_code[9]}}, ~conv_code[9], conv_code[8:0]};
                    end else begin
                        result_nxt = {6'h00, conv_code};
                    end
                    valid_nxt = 1'b1;
                    state_nxt = adc_input_mux_pkg::ST_IDLE;
                end
            end
            default: state_nxt = adc_input_mux_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r  <= adc_input_mux_pkg::ST_IDLE;
            route_r  <= '{pos_src: adc_input_mux_pkg::SRC_AIN0,
                          neg_src: adc_input_mux_pkg::SRC_GND,
                          differential: 1'b0, gain: `GAIN_RESET, port_pins: 8'h00};
            result_r <= 16'h0000;
            valid_r  <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            route_r  <= route_nxt;
            result_r <= result_nxt;
            valid_r  <= valid_nxt;
        end
    end

    assign sfr_rdata          = rdata_r;
    assign converter_shutdown = ~enable_r;
    assign conv_busy          = (state_r == adc_input_mux_pkg::ST_CONVERT);
    assign route              = route_r;
    assign result             = result_r;
    assign result_valid       = valid_r;

    // even pins share one mux input, odd pins the other (wired-OR in the pad ring)
    logic even_group_live;
    logic odd_group_live;
    assign even_group_live = |(route_r.port_pins & `EVEN_PIN_MASK);
    assign odd_group_live  = |(route_r.port_pins & `ODD_PIN_MASK);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_shutdown_no_start: assert property (
        converter_shutdown |=> state_r == adc_input_mux_pkg::ST_IDLE)
        else $error("conversion active while shut down");
    a_reserved_read_zero: assert property (
        sfr_rd && sfr_addr == `INPUT_PAIR_CONFIG_ADDR |=> sfr_rdata[7:4] == 4'h0)
        else $error("reserved pair bits read non-zero");
    a_route_frozen: assert property (
        conv_busy && $past(conv_busy) |-> $stable(route))
        else $error("route changed during conversion");
    a_start_latches: assert property (
        !conv_busy && enable_r && conv_start |=> route == $past(decoded))
        else $error("route not taken at start");
    a_diff_signed: assert property (
        result_valid && route.differential |-> result[15:10] == {6{result[9]}})
        else $error("differential result not sign extended");
    a_single_unsigned: assert property (
        result_valid && !route.differential |-> result[15:10] == 6'h00)
        else $error("single-ended result not unsigned");
    a_temp_code: assert property (
        chan_r[3] |-> decoded.pos_src == adc_input_mux_pkg::SRC_TEMP)
        else $error("1xxx code not temperature");
    a_pair01_diff: assert property (
        chan_r[3:1] == 3'h0 && pair_cfg_r[0] |-> decoded.differential
            && decoded.neg_src == adc_input_mux_pkg::SRC_AIN1)
        else $error("pair 0/1 not differential");
    a_hv_signed: assert property (
        chan_r == `CHAN_HV && pair_cfg_r[2] |->
            decoded.neg_src == adc_input_mux_pkg::SRC_HV_REF)
        else $error("hv signed mode not referenced");
    // group flags checked pin by pin, independent of the mask constants
    a_pins_reach: assert property (
        even_group_live == (route.port_pins[0] | route.port_pins[2]
                            | route.port_pins[4] | route.port_pins[6]))
        else $error("even group mismatch");
    a_odd_pins_reach: assert property (
        odd_group_live == (route.port_pins[1] | route.port_pins[3]
                           | route.port_pins[5] | route.port_pins[7]))
        else $error("odd group mismatch");
    a_gain_write: assert property (
        sfr_wr && sfr_addr == `CONVERTER_CONFIG_ADDR |=>
            {5'h00, gain_r} == ($past(sfr_wdata) & 8'h07))
        else $error("gain field not written");

    c_diff_result:   cover property (result_valid && route.differential);
    c_abort:         cover property (conv_busy ##1 converter_shutdown);
    c_port_pair:     cover property (conv_start && decoded.pos_src == adc_input_mux_pkg::SRC_EVEN_PORT
                                     && decoded.differential);
    c_odd_live:      cover property (odd_group_live && even_group_live);

endmodule : adc_input_mux_config
`default_nettype wire

// File: tb/analog_core_model.sv
// behavioural model of the analog conversion core that answers the input control
`timescale 1ns/1ns
`default_nettype none

module analog_core_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       busy,
    input  wire logic [7:0] delay,
    input  wire logic [9:0] next_code,
    output logic            done,
    output logic [9:0]      code
);
    logic [7:0] cnt_r;

    // done pulses once, delay cycles after busy is seen; the code flips every
    // cycle outside done, so a capture on the wrong edge gives a wrong result
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 8'h00;
            done  <= 1'h0;
            code  <= 10'h155;
        end else if (!busy) begin
            cnt_r <= 8'h00;
            done  <= 1'h0;
            code  <= ~code;
        end else begin
            cnt_r <= (cnt_r == 8'hFF) ? cnt_r : cnt_r + 8'h01;
            done  <= (cnt_r == delay);
            code  <= (cnt_r == delay) ? next_code : ~code;
        end
    end
endmodule : analog_core_model

`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the converter input control
`timescale 1ns/1ns
`default_nettype none
`include "adc_input_mux_map.svh"

module tb_top;
    logic                      clk = 1'h0;
    logic                      rst_n;
    logic [7:0]                sfr_addr;
    logic                      sfr_wr;
    logic                      sfr_rd;
    logic [7:0]                sfr_wdata;
    logic [7:0]                sfr_rdata;
    logic                      conv_start;
    logic                      conv_done;
    logic [9:0]                conv_code;
    logic                      converter_shutdown;
    logic                      conv_busy;
    adc_input_mux_pkg::route_t route;
    logic [15:0]               result;
    logic                      result_valid;
    logic [7:0]                done_delay;
    logic [9:0]                next_code;
    logic                      seen;
    logic [3:0]                chc;
    logic [2:0]                g;
    logic [9:0]                c;
    int                        n_mismatch = 0;
    int                        comparisons = 0;
    logic [2:0] gtab [6] = '{`GAIN_X1, `GAIN_X2, `GAIN_X4, `GAIN_X8, `GAIN_X16, `GAIN_HALF};
    logic [9:0] ctab [4] = '{10'h000, 10'h3FF, 10'h200, 10'h1FF};

    // 50 MHz core clock
    always #10 clk = ~clk;

    adc_input_mux_config adc_input_mux_config_inst (.clk(clk), .rst_n(rst_n),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .conv_start(conv_start), .conv_done(conv_done),
        .conv_code(conv_code), .converter_shutdown(converter_shutdown),
        .conv_busy(conv_busy), .route(route), .result(result), .result_valid(result_valid));
    analog_core_model analog_core_model_inst (.clk(clk), .rst_n(rst_n), .busy(conv_busy),
        .delay(done_delay), .next_code(next_code), .done(conv_done), .code(conv_code));

    task automatic check(input logic [22:0] sv, input logic [22:0] ev, input string msg);
        comparisons++;
        if (sv !== ev) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t ns: %s", $time, msg);
        end
    endtask : check

    // one-cycle strobes launched off the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'h1;
        @(negedge clk);
        sfr_wr = 1'h0;
    endtask : wr

    // read data lands one edge after the strobe; compared under a mask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'h1;
        @(negedge clk);
        sfr_rd = 1'h0;
        check({15'h0, sfr_rdata & m}, {15'h0, e}, "register read");
    endtask : rd

    task automatic start_conv(input logic [9:0] cv);
        next_code = cv;
        @(negedge clk);
        conv_start = 1'h1;
        @(negedge clk);
        conv_start = 1'h0;
    endtask : start_conv

    // bounded wait: a lost done must not hang the run
    task automatic finish_conv(input logic [15:0] er);
        int k;
        k = 0;
        while (result_valid !== 1'h1 && k < 80) begin
            @(negedge clk);
            k++;
        end
        check({22'h0, result_valid}, 23'h1, "result valid");
        check({7'h0, result}, {7'h0, er}, "result word");
    endtask : finish_conv

    function automatic adc_input_mux_pkg::route_t exp_route(input logic [3:0] cfg,
        input logic [3:0] ch, input logic [2:0] gn, input logic [7:0] p);
        adc_input_mux_pkg::route_t r;
        r = '{adc_input_mux_pkg::src_t'(ch), adc_input_mux_pkg::SRC_GND, 1'h0, gn, p};
        if (ch[3]) begin
            r.pos_src = adc_input_mux_pkg::SRC_TEMP;
        end else if (cfg[ch[2:1]]) begin
            r.pos_src = adc_input_mux_pkg::src_t'({ch[3:1], 1'h0});
            r.neg_src = adc_input_mux_pkg::src_t'({ch[3:1], 1'h1});
            if (ch[2:1] == 2'h2) r.neg_src = adc_input_mux_pkg::SRC_HV_REF;
            r.differential = 1'h1;
        end
        return r;
    endfunction : exp_route

    function automatic logic [15:0] exp_result(input logic d, input logic [9:0] cv);
        return d ? {{7{~cv[9]}}, cv[8:0]} : {6'h00, cv};
    endfunction : exp_result

    task automatic print_verdict();
        if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict

    // watchdog, well past the expected few thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        adc_input_mux_pkg::route_t er;
        rst_n = 1'h0;
        sfr_addr = 8'h00;
        sfr_wr = 1'h0;
        sfr_rd = 1'h0;
        sfr_wdata = 8'h00;
        conv_start = 1'h0;
        done_delay = 8'h01;
        next_code = 10'h000;
        repeat (20) @(posedge clk);
        @(negedge clk) rst_n = 1'h1;
        check({22'h0, converter_shutdown}, 23'h1, "shutdown after reset");
        check({3'h0, route}, {3'h0, adc_input_mux_pkg::SRC_AIN0, adc_input_mux_pkg::SRC_GND,
              1'h0, `GAIN_X1, `PORT_PIN_SELECT_RESET}, "route after reset");
        rd(`INPUT_PAIR_CONFIG_ADDR, 8'hFF, 8'h00);
        rd(`PORT_PIN_SELECT_ADDR, 8'hFF, 8'h00);
        rd(`CONVERTER_CONFIG_ADDR, 8'h07, `GAIN_X1);
        wr(`INPUT_PAIR_CONFIG_ADDR, 8'hFF);
        rd(`INPUT_PAIR_CONFIG_ADDR, 8'hFF, 8'h0F);
        wr(`CHANNEL_SELECT_ADDR, 8'hF3);
        rd(`CHANNEL_SELECT_ADDR, 8'hFF, 8'h03);
        rd(8'hC0, 8'hFF, 8'h00);
        start_conv(10'h000);
        check({22'h0, conv_busy}, 23'h0, "start while disabled");
        wr(`CONVERTER_CONTROL_ADDR, 8'h80);
        check({22'h0, converter_shutdown}, 23'h0, "enabled");
        // every pairing against every channel, gains and pin masks rotating
        for (int cfg = 0; cfg < 16; cfg++) begin
            for (int ch = 0; ch < 9; ch++) begin
                chc = (ch == 8) ? {1'h1, 3'(cfg)} : 4'(ch);
                g = gtab[(cfg + ch) % 6];
                c = ctab[(cfg + ch) % 4];
                done_delay = (ch == 3) ? 8'h14 : 8'h01;
                er = exp_route(4'(cfg), chc, g, {4'(cfg), ~4'(cfg)});
                wr(`INPUT_PAIR_CONFIG_ADDR, {4'h0, 4'(cfg)});
                wr(`CHANNEL_SELECT_ADDR, {4'h0, chc});
                wr(`CONVERTER_CONFIG_ADDR, {5'h00, g});
                wr(`PORT_PIN_SELECT_ADDR, {4'(cfg), ~4'(cfg)});
                rd(`PORT_PIN_SELECT_ADDR, 8'hFF, {4'(cfg), ~4'(cfg)});
                rd(`CONVERTER_CONFIG_ADDR, 8'h07, {5'h00, g});
                start_conv(c);
                check({22'h0, conv_busy}, 23'h1, "busy after start");
                check({3'h0, route}, {3'h0, er}, "route");
                finish_conv(exp_result(er.differential, c));
            end
        end
        // writes and a second start during a conversion leave the latched route alone
        done_delay = 8'h1E;
        er = exp_route(4'h0, 4'h2, `GAIN_X1, 8'h00);
        wr(`INPUT_PAIR_CONFIG_ADDR, 8'h00);
        wr(`CHANNEL_SELECT_ADDR, 8'h02);
        wr(`CONVERTER_CONFIG_ADDR, 8'h00);
        wr(`PORT_PIN_SELECT_ADDR, 8'h00);
        start_conv(10'h2A5);
        rd(`CONVERTER_CONTROL_ADDR, 8'hFF, 8'h90);
        wr(`CHANNEL_SELECT_ADDR, 8'h07);
        wr(`CONVERTER_CONFIG_ADDR, {5'h00, `GAIN_X16});
        wr(`INPUT_PAIR_CONFIG_ADDR, 8'h08);
        start_conv(10'h2A5);
        check({3'h0, route}, {3'h0, er}, "route frozen in conversion");
        finish_conv(16'h02A5);
        start_conv(10'h0FF);
        er = exp_route(4'h8, 4'h7, `GAIN_X16, 8'h00);
        check({3'h0, route}, {3'h0, er}, "route at next start");
        finish_conv(16'hFEFF);
        // enable cleared mid-conversion: back to idle, no result
        start_conv(10'h111);
        wr(`CONVERTER_CONTROL_ADDR, 8'h00);
        @(negedge clk);
        check({22'h0, conv_busy, converter_shutdown}, 23'h1, "abort on disable");
        seen = 1'h0;
        repeat (40) @(negedge clk) if (result_valid === 1'h1) seen = 1'h1;
        check({22'h0, seen}, 23'h0, "no result after abort");
        rd(`CONVERTER_CONTROL_ADDR, 8'hFF, 8'h00);
        print_verdict();
    end
endmodule : tb_top

`default_nettype wire
